//--- rtl/gpcfg_top.sv
// Summary of operation
// R1 - Bit 0 set means input, clear means output.
// R2 - Bit 1 set inverts the pin value.
// R3 - Bit 7 set means open drain, else push-pull.
// R4 - Standby reset loads every control register 0x01.
// R5 - Pin 3.3 also clears on main/hard reset.
// R6 - Pin 2.7 bit 2 routes management interrupt.
// R7 - Pin 3.0: address 2, select 2, SMBus clock.
// R8 - Pin 3.1: address 3, select 3, fan tachometer.
// R9 - Pin 3.2: address 0, SMBus data, 11 reserved.
// R10 - Pin 3.3: address 1, fan drive, 11 reserved.
// R11 - Pin 3.4 bit 2 selects legacy interrupt A.
// R12 - Pin 3.5 bit 2 selects legacy interrupt B.
// R13 - Bits between the function select and bit 7 are reserved.
// R14 - Reserved bits ignore writes, read zero.
// R15 - Polarity applies to input and output paths.
`timescale 1ns/100ps
`default_nettype none

module gpcfg_top
  import gpcfg_pkg::*;
#(
  parameter int ADDR_W = GPCFG_ADDR_W
)
(
  input  wire logic                  core_clk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  main_por_in,
  input  wire logic                  hard_rst_in,
  // AXI4-Lite slave.
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output var  logic                  s_axi_awready_out,
  input  wire logic [31:0]           s_axi_wdata_in,
  input  wire logic [3:0]            s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output var  logic                  s_axi_wready_out,
  output var  logic [1:0]            s_axi_bresp_out,
  output var  logic                  s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output var  logic                  s_axi_arready_out,
  output var  logic [31:0]           s_axi_rdata_out,
  output var  logic [1:0]            s_axi_rresp_out,
  output var  logic                  s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  // Pads; bit 0 is pin 2.7, bits 1 to 6 are pins 3.0 to 3.5.
  input  wire logic [GPCFG_NPIN-1:0] pad_in,
  output var  logic [GPCFG_NPIN-1:0] pad_out,
  output var  logic [GPCFG_NPIN-1:0] pad_oe_out,
  // Alternate function units.
  input  wire logic                  sys_mgmt_irq_in,
  input  wire logic [3:0]            ext_bus_addr_line_in,
  input  wire logic                  ext_bus_chip_sel_2_in,
  input  wire logic                  ext_bus_chip_sel_3_in,
  input  wire logic                  smbus_clk_drive_in,
  input  wire logic                  smbus_data_pin_drive_in,
  input  wire logic                  fan_speed_drive_in,
  output var  logic                  smbus_clk_sense_out,
  output var  logic                  smbus_data_pin_sense_out,
  output var  logic                  fan_speed_sense_out,
  output var  logic                  legacy_irq_input_a_out,
  output var  logic                  legacy_irq_input_b_out
);

  // ******************************************************************
  // State.
  // ******************************************************************
  typedef struct packed {
    logic [GPCFG_NPIN-1:0][7:0] cfg;
    logic [GPCFG_NPIN-1:0]      dout;
    logic [ADDR_W-1:0]          awaddr;
    logic                       aw_have;
    logic [7:0]                 wdata;
    logic                       wstrb0;
    logic                       w_have;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [1:0]                 rresp;
    logic [31:0]                rdata;
    logic                       clk_sense;
    logic                       data_sense;
    logic                       tach_sense;
    logic                       irq_a;
    logic                       irq_b;
  } gpcfg_state_s;

  localparam gpcfg_state_s GPCFG_ST_RST = '{
    cfg:     {GPCFG_NPIN{GPCFG_CFG_RST_STBY}},
    dout:    GPCFG_DATA_RST,
    awready: 1'b1,
    wready:  1'b1,
    arready: 1'b1,
    default: '0
  };

  localparam logic [3:0] GPCFG_HIT_DATA  = 4'h7;
  localparam logic [3:0] GPCFG_HIT_STATE = 4'h8;
  localparam logic [3:0] GPCFG_HIT_NONE  = 4'hf;

  gpcfg_state_s          st;
  gpcfg_state_s          next_st;
  logic [GPCFG_NPIN-1:0] alt_sel;
  logic [GPCFG_NPIN-1:0] alt_val;
  logic [GPCFG_NPIN-1:0] in_val;

  // ******************************************************************
  // Helpers.
  // ******************************************************************

  // Maps a byte address to a register slot; only aligned words hit.
  function automatic logic [3:0] gpcfg_decode(
    input logic [ADDR_W-1:0] a
  );
    logic [3:0] hit;
    hit = GPCFG_HIT_NONE;
    for (int i = 0; i < GPCFG_NPIN; i++) begin
      if (a == ADDR_W'({GPCFG_IDX_TAB[i], 2'b00})) begin
        hit = 4'(i);
      end
    end
    if (a == ADDR_W'({GPCFG_IDX_DATA_OUT, 2'b00})) begin
      hit = GPCFG_HIT_DATA;
    end
    if (a == ADDR_W'({GPCFG_IDX_PIN_STATE, 2'b00})) begin
      hit = GPCFG_HIT_STATE;
    end
    return hit;
  endfunction : gpcfg_decode

  // Writable bits of one pin: the wider select only on pins 3.0-3.3.
  function automatic logic [7:0] gpcfg_wmask(input int pin);
    return GPCFG_FN2_PINS[pin] ? GPCFG_MASK_FN2 : GPCFG_MASK_FN1; // R13
  endfunction : gpcfg_wmask

  // ******************************************************************
  // Alternate function routing.
  // ******************************************************************
  always_comb begin
    gpcfg_fn_e fn30;
    gpcfg_fn_e fn31;
    gpcfg_fn_e fn32;
    gpcfg_fn_e fn33;
    fn30 = gpcfg_fn_e'(st.cfg[GPCFG_PIN_3_0][GPCFG_BIT_FN_HI:GPCFG_BIT_FN_LO]);
    fn31 = gpcfg_fn_e'(st.cfg[GPCFG_PIN_3_1][GPCFG_BIT_FN_HI:GPCFG_BIT_FN_LO]);
    fn32 = gpcfg_fn_e'(st.cfg[GPCFG_PIN_3_2][GPCFG_BIT_FN_HI:GPCFG_BIT_FN_LO]);
    fn33 = gpcfg_fn_e'(st.cfg[GPCFG_PIN_3_3][GPCFG_BIT_FN_HI:GPCFG_BIT_FN_LO]);
    alt_sel = '0;
    alt_val = '0;

    alt_sel[GPCFG_PIN_2_7] = st.cfg[GPCFG_PIN_2_7][GPCFG_BIT_FN_LO]; // R6
    alt_val[GPCFG_PIN_2_7] = sys_mgmt_irq_in;                        // R6

    unique case (fn30)
      GPCFG_FN_11: begin
        alt_sel[GPCFG_PIN_3_0] = 1'b1;                               // R7
        alt_val[GPCFG_PIN_3_0] = ext_bus_addr_line_in[2];
      end
      GPCFG_FN_10: begin
        alt_sel[GPCFG_PIN_3_0] = 1'b1;                               // R7
        alt_val[GPCFG_PIN_3_0] = ext_bus_chip_sel_2_in;
      end
      GPCFG_FN_01: begin
        alt_sel[GPCFG_PIN_3_0] = 1'b1;                               // R7
        alt_val[GPCFG_PIN_3_0] = smbus_clk_drive_in;
      end
      GPCFG_FN_GPIO: begin
      end
    endcase

    // The tachometer is an input, so code 01 leaves the output on data.
    unique case (fn31)
      GPCFG_FN_11: begin
        alt_sel[GPCFG_PIN_3_1] = 1'b1;                               // R8
        alt_val[GPCFG_PIN_3_1] = ext_bus_addr_line_in[3];
      end
      GPCFG_FN_10: begin
        alt_sel[GPCFG_PIN_3_1] = 1'b1;                               // R8
        alt_val[GPCFG_PIN_3_1] = ext_bus_chip_sel_3_in;
      end
      GPCFG_FN_01, GPCFG_FN_GPIO: begin
      end
    endcase

    // Reserved code 11 behaves as plain GPIO.
    unique case (fn32)
      GPCFG_FN_10: begin
        alt_sel[GPCFG_PIN_3_2] = 1'b1;                               // R9
        alt_val[GPCFG_PIN_3_2] = ext_bus_addr_line_in[0];
      end
      GPCFG_FN_01: begin
        alt_sel[GPCFG_PIN_3_2] = 1'b1;                               // R9
        alt_val[GPCFG_PIN_3_2] = smbus_data_pin_drive_in;
      end
      GPCFG_FN_11, GPCFG_FN_GPIO: begin
      end
    endcase

    unique case (fn33)
      GPCFG_FN_10: begin
        alt_sel[GPCFG_PIN_3_3] = 1'b1;                               // R10
        alt_val[GPCFG_PIN_3_3] = ext_bus_addr_line_in[1];
      end
      GPCFG_FN_01: begin
        alt_sel[GPCFG_PIN_3_3] = 1'b1;                               // R10
        alt_val[GPCFG_PIN_3_3] = fan_speed_drive_in;
      end
      GPCFG_FN_11, GPCFG_FN_GPIO: begin
      end
    endcase
  end

  // ******************************************************************
  // Next state: bus slave, registers and input senses.
  // ******************************************************************
  always_comb begin
    logic [3:0] whit;
    logic [3:0] rhit;
    whit = GPCFG_HIT_NONE;
    rhit = GPCFG_HIT_NONE;
    next_st = st;

    // Address and data are caught independently, in either order.
    if (s_axi_awvalid_in && st.awready) begin
      next_st.awaddr  = s_axi_awaddr_in;
      next_st.aw_have = 1'b1;
    end
    if (s_axi_wvalid_in && st.wready) begin
      next_st.wdata  = s_axi_wdata_in[7:0];
      next_st.wstrb0 = s_axi_wstrb_in[0];
      next_st.w_have = 1'b1;
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end

    if (st.aw_have && st.w_have && !st.bvalid) begin
      whit = gpcfg_decode(st.awaddr);
      next_st.aw_have = 1'b0;
      next_st.w_have  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = GPCFG_RESP_OKAY;
      if (whit < 4'(GPCFG_NPIN)) begin
        if (st.wstrb0) begin
          next_st.cfg[whit] = st.wdata & gpcfg_wmask(int'(whit)); // R14
        end
      end else if (whit == GPCFG_HIT_DATA) begin
        if (st.wstrb0) begin
          next_st.dout = st.wdata[GPCFG_NPIN-1:0];
        end
      end else if (whit == GPCFG_HIT_STATE) begin
        next_st.bresp = GPCFG_RESP_OKAY;
      end else begin
        next_st.bresp = GPCFG_RESP_SLVERR;
      end
    end

    // Main power and hard reset take priority over a same-cycle write.
    if (main_por_in || hard_rst_in) begin
      next_st.cfg[GPCFG_PIN_3_3] = GPCFG_CFG_RST_MAIN;            // R5
    end

    next_st.awready = !next_st.aw_have && !next_st.bvalid;
    next_st.wready  = !next_st.w_have && !next_st.bvalid;

    // Reads answer on the same edge that takes the address.
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && st.arready) begin
      rhit = gpcfg_decode(s_axi_araddr_in);
      next_st.rvalid = 1'b1;
      next_st.rresp  = GPCFG_RESP_OKAY;
      next_st.rdata  = '0;
      if (rhit < 4'(GPCFG_NPIN)) begin
        next_st.rdata[7:0] = st.cfg[rhit];                        // R14
      end else if (rhit == GPCFG_HIT_DATA) begin
        next_st.rdata[GPCFG_NPIN-1:0] = st.dout;
      end else if (rhit == GPCFG_HIT_STATE) begin
        next_st.rdata[GPCFG_NPIN-1:0] = in_val;
      end else begin
        next_st.rresp = GPCFG_RESP_SLVERR;
      end
    end
    next_st.arready = !next_st.rvalid;

    // Senses read zero while their function is not selected.
    next_st.clk_sense  = in_val[GPCFG_PIN_3_0] &&
      (st.cfg[GPCFG_PIN_3_0][GPCFG_BIT_FN_HI:GPCFG_BIT_FN_LO] ==
       GPCFG_FN_01);                                              // R7
    next_st.tach_sense = in_val[GPCFG_PIN_3_1] &&
      (st.cfg[GPCFG_PIN_3_1][GPCFG_BIT_FN_HI:GPCFG_BIT_FN_LO] ==
       GPCFG_FN_01);                                              // R8
    next_st.data_sense = in_val[GPCFG_PIN_3_2] &&
      (st.cfg[GPCFG_PIN_3_2][GPCFG_BIT_FN_HI:GPCFG_BIT_FN_LO] ==
       GPCFG_FN_01);                                              // R9
    next_st.irq_a = in_val[GPCFG_PIN_3_4] &&
      st.cfg[GPCFG_PIN_3_4][GPCFG_BIT_FN_LO];                     // R11
    next_st.irq_b = in_val[GPCFG_PIN_3_5] &&
      st.cfg[GPCFG_PIN_3_5][GPCFG_BIT_FN_LO];                     // R12
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= GPCFG_ST_RST;                                         // R4
    end else begin
      st <= next_st;
    end
  end

  // ******************************************************************
  // Pad drivers.
  // ******************************************************************
  for (genvar i = 0; i < GPCFG_NPIN; i++) begin : g_pin
    gpcfg_pin u_pin (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .cfg_in      (st.cfg[i]),
      .alt_sel_in  (alt_sel[i]),
      .alt_val_in  (alt_val[i]),
      .gpio_val_in (st.dout[i]),
      .pad_in      (pad_in[i]),
      .pad_out     (pad_out[i]),
      .pad_oe_out  (pad_oe_out[i]),
      .in_val_out  (in_val[i])
    );
  end

  // ******************************************************************
  // Outputs.
  // ******************************************************************
  assign s_axi_awready_out        = st.awready;
  assign s_axi_wready_out         = st.wready;
  assign s_axi_bresp_out          = st.bresp;
  assign s_axi_bvalid_out         = st.bvalid;
  assign s_axi_arready_out        = st.arready;
  assign s_axi_rdata_out          = st.rdata;
  assign s_axi_rresp_out          = st.rresp;
  assign s_axi_rvalid_out         = st.rvalid;
  assign smbus_clk_sense_out      = st.clk_sense;
  assign smbus_data_pin_sense_out = st.data_sense;
  assign fan_speed_sense_out      = st.tach_sense;
  assign legacy_irq_input_a_out   = st.irq_a;
  assign legacy_irq_input_b_out   = st.irq_b;

endmodule : gpcfg_top

`default_nettype wire

//--- rtl/gpcfg_pkg.sv
`default_nettype none

package gpcfg_pkg;

  // ******************************************************************
  // Pin numbering inside the group.
  // ******************************************************************
  localparam int GPCFG_NPIN    = 7;
  localparam int GPCFG_PIN_2_7 = 0;
  localparam int GPCFG_PIN_3_0 = 1;
  localparam int GPCFG_PIN_3_1 = 2;
  localparam int GPCFG_PIN_3_2 = 3;
  localparam int GPCFG_PIN_3_3 = 4;
  localparam int GPCFG_PIN_3_4 = 5;
  localparam int GPCFG_PIN_3_5 = 6;

  // ******************************************************************
  // Register indices; the byte address is four times the index.
  // ******************************************************************
  localparam int         GPCFG_ADDR_W         = 9;
  localparam logic [6:0] GPCFG_IDX_PIN_2_7    = 7'h32;
  localparam logic [6:0] GPCFG_IDX_PIN_3_0    = 7'h33;
  localparam logic [6:0] GPCFG_IDX_PIN_3_1    = 7'h34;
  localparam logic [6:0] GPCFG_IDX_PIN_3_2    = 7'h35;
  localparam logic [6:0] GPCFG_IDX_PIN_3_3    = 7'h36;
  localparam logic [6:0] GPCFG_IDX_PIN_3_4    = 7'h37;
  localparam logic [6:0] GPCFG_IDX_PIN_3_5    = 7'h38;
  localparam logic [6:0] GPCFG_IDX_DATA_OUT   = 7'h40;
  localparam logic [6:0] GPCFG_IDX_PIN_STATE  = 7'h41;
  localparam logic [GPCFG_NPIN-1:0][6:0] GPCFG_IDX_TAB = {
    GPCFG_IDX_PIN_3_5, GPCFG_IDX_PIN_3_4, GPCFG_IDX_PIN_3_3,
    GPCFG_IDX_PIN_3_2, GPCFG_IDX_PIN_3_1, GPCFG_IDX_PIN_3_0,
    GPCFG_IDX_PIN_2_7};

  // ******************************************************************
  // Control register fields, masks and reset values.
  // ******************************************************************
  localparam int         GPCFG_BIT_DIR        = 0;
  localparam int         GPCFG_BIT_POL        = 1;
  localparam int         GPCFG_BIT_FN_LO      = 2;
  localparam int         GPCFG_BIT_FN_HI      = 3;
  localparam int         GPCFG_BIT_OTYPE      = 7;
  localparam logic [7:0] GPCFG_MASK_FN1       = 8'h87;
  localparam logic [7:0] GPCFG_MASK_FN2       = 8'h8f;
  localparam logic [6:0] GPCFG_FN2_PINS       = 7'h1e;
  localparam logic [7:0] GPCFG_CFG_RST_STBY   = 8'h01;
  localparam logic [7:0] GPCFG_CFG_RST_MAIN   = 8'h00;
  localparam logic [6:0] GPCFG_DATA_RST       = 7'h00;

  typedef enum logic [1:0] {
    GPCFG_FN_GPIO = 2'h0,
    GPCFG_FN_01   = 2'h1,
    GPCFG_FN_10   = 2'h2,
    GPCFG_FN_11   = 2'h3
  } gpcfg_fn_e;

  // ******************************************************************
  // Bus answers.
  // ******************************************************************
  localparam logic [1:0] GPCFG_RESP_OKAY      = 2'h0;
  localparam logic [1:0] GPCFG_RESP_SLVERR    = 2'h2;

endpackage : gpcfg_pkg

`default_nettype wire

//--- rtl/gpcfg_pin.sv
`timescale 1ns/100ps
`default_nettype none

module gpcfg_pin
  import gpcfg_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       rstn_in,
  input  wire logic [7:0] cfg_in,
  input  wire logic       alt_sel_in,
  input  wire logic       alt_val_in,
  input  wire logic       gpio_val_in,
  input  wire logic       pad_in,
  output var  logic       pad_out,
  output var  logic       pad_oe_out,
  output var  logic       in_val_out
);

  typedef struct packed {
    logic out;
    logic oe;
    logic val;
  } gpcfg_pin_s;

  gpcfg_pin_s st;
  gpcfg_pin_s next_st;

  always_comb begin
    logic drv;
    drv = 1'b0;
    next_st = st;
    drv = (alt_sel_in ? alt_val_in : gpio_val_in)
          ^ cfg_in[GPCFG_BIT_POL];                           // R15 R2
    if (cfg_in[GPCFG_BIT_OTYPE]) begin                       // R3
      // Open drain only ever pulls low; a high is left to the pull-up.
      next_st.out = 1'b0;
      next_st.oe  = ~cfg_in[GPCFG_BIT_DIR] & ~drv;           // R1
    end else begin
      next_st.out = drv;
      next_st.oe  = ~cfg_in[GPCFG_BIT_DIR];                  // R1
    end
    next_st.val = pad_in ^ cfg_in[GPCFG_BIT_POL];            // R15 R2
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pad_out    = st.out;
  assign pad_oe_out = st.oe;
  assign in_val_out = st.val;

endmodule : gpcfg_pin

`default_nettype wire

//--- bench/gpcfg_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module gpcfg_top_asserts
  import gpcfg_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       rstn_in,
  input wire logic       main_por_in,
  input wire logic       hard_rst_in,
  input wire logic       s_axi_awvalid_in,
  input wire logic       s_axi_awready_out,
  input wire logic       s_axi_wvalid_in,
  input wire logic       s_axi_wready_out,
  input wire logic       s_axi_bvalid_out,
  input wire logic       s_axi_bready_in,
  input wire logic       s_axi_arvalid_in,
  input wire logic       s_axi_arready_out,
  input wire logic       s_axi_rvalid_out,
  input wire logic       s_axi_rready_in,
  input wire logic [6:0] pad_oe_out
);
  // ******************************************************************
  // Bus and pad checks.
  // ******************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  // Pads may only drive once software or a main reset made one an output.
  logic touched;
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      touched <= 1'b0;
    end else if (s_axi_bvalid_out || main_por_in || hard_rst_in) begin
      touched <= 1'b1;
    end
  end

  property p_b_once;
    s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out;
  endproperty
  a_b_once: assert property (p_b_once)
    else $error("write answer repeated");
  property p_r_once;
    s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out;
  endproperty
  a_r_once: assert property (p_r_once)
    else $error("read answer repeated");
  property p_aw_block;
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write taken while answer pending");
  property p_ar_block;
    s_axi_rvalid_out |-> !s_axi_arready_out;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read taken while answer pending");
  property p_w_ans;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out |-> ##[1:3] s_axi_bvalid_out;
  endproperty
  a_w_ans: assert property (p_w_ans)
    else $error("write answer late");
  property p_r_ans;
    s_axi_arvalid_in && s_axi_arready_out |-> ##[1:2] s_axi_rvalid_out;
  endproperty
  a_r_ans: assert property (p_r_ans)
    else $error("read answer late");
  property p_oe_rst;
    !touched |-> pad_oe_out == 7'h00;
  endproperty
  a_oe_rst: assert property (p_oe_rst)
    else $error("pad driven while all pins are inputs");
  property p_main_rst;
    main_por_in || hard_rst_in |-> ##2 pad_oe_out[4];
  endproperty
  a_main_rst: assert property (p_main_rst)
    else $error("pin 3.3 not output after main reset");
endmodule : gpcfg_top_asserts

bind gpcfg_top gpcfg_top_asserts u_chk (
  .core_clk_in, .rstn_in, .main_por_in, .hard_rst_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
  .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in, .pad_oe_out);

`default_nettype wire

//--- bench/gpcfg_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module gpcfg_top_tb
  import gpcfg_pkg::*;
;
  // ******************************************************************
  // Stimulus, bus tasks and scenarios.
  // ******************************************************************
  logic        clk = 1'b0, rstn = 1'b0, mpor = 1'b0, hrst = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic        bready = 1'b0, rready = 1'b0;
  logic [8:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdv;
  logic [3:0]  wstrb = 4'hf;
  logic [6:0]  pad_i = '0;
  logic [9:0]  alt = '0;
  logic [1:0]  rsp;
  int          err_total = 0, checks_done = 0, cyc = 0;
  wire logic        awr, wr, bv, arr, rv;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [6:0]  pad_o, pad_oe;
  wire logic [4:0]  sense;

  gpcfg_top dut (
    .core_clk_in(clk), .rstn_in(rstn), .main_por_in(mpor),
    .hard_rst_in(hrst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rready),
    .pad_in(pad_i), .pad_out(pad_o), .pad_oe_out(pad_oe),
    .sys_mgmt_irq_in(alt[0]), .ext_bus_addr_line_in(alt[4:1]),
    .ext_bus_chip_sel_2_in(alt[5]), .ext_bus_chip_sel_3_in(alt[6]),
    .smbus_clk_drive_in(alt[7]), .smbus_data_pin_drive_in(alt[8]),
    .fan_speed_drive_in(alt[9]), .smbus_clk_sense_out(sense[0]),
    .smbus_data_pin_sense_out(sense[1]), .fan_speed_sense_out(sense[2]),
    .legacy_irq_input_a_out(sense[3]), .legacy_irq_input_b_out(sense[4]));

  always #12.5 clk = ~clk;

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // The ceiling is more than twenty times the under one thousand cycles the run needs.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [8:0] ca(input int p);
    return {GPCFG_IDX_TAB[p], 2'b00};
  endfunction : ca

  // Each transfer starts one edge on, so no signal is assigned twice at once.
  task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (bv === 1'b1) break;
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [8:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (rv === 1'b1) break;
      if (arr === 1'b1) arv <= 1'b0;
    end
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd_reg

  task automatic cfg_all(input logic [7:0] v);
    for (int p = 0; p < 7; p++) wr_reg(ca(p), {24'h0, v});
    repeat (3) @(posedge clk);
  endtask : cfg_all

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
  endtask : do_reset

  task automatic t_reset_vals();
    for (int p = 0; p < 7; p++) begin
      rd_reg(ca(p));
      chk(rdv, 32'h01);
      chk(rsp, GPCFG_RESP_OKAY);
    end
    chk(pad_oe, 7'h00);
  endtask : t_reset_vals

  task automatic t_masks();
    for (int p = 0; p < 7; p++) begin
      wr_reg(ca(p), 32'hffffffff);
      rd_reg(ca(p));
      chk(rdv, (p >= 1 && p <= 4) ? 32'h8f : 32'h87);
      wr_reg(ca(p), 32'h01);
    end
  endtask : t_masks

  task automatic t_bus_err();
    rd_reg(9'h1fc);
    chk(rsp, GPCFG_RESP_SLVERR);
    chk(rdv, 32'h0);
    wr_reg(9'h1fc, 32'hff);
    chk(rsp, GPCFG_RESP_SLVERR);
    wr_reg(9'h104, 32'h7f);
    chk(rsp, GPCFG_RESP_OKAY);
    rd_reg(9'h104);
    chk(rdv, 32'h0);
    wstrb <= 4'h0;
    wr_reg(ca(5), 32'h84);
    wstrb <= 4'hf;
    rd_reg(ca(5));
    chk(rdv, 32'h01);
  endtask : t_bus_err

  task automatic t_drive();
    wr_reg(9'h100, 32'h7f);
    rd_reg(9'h100);
    chk(rdv, 32'h7f);
    cfg_all(8'h00);
    chk(pad_oe, 7'h7f);
    chk(pad_o, 7'h7f);
    cfg_all(8'h02);
    chk(pad_o, 7'h00);
    cfg_all(8'h80);
    chk(pad_oe, 7'h00);
    wr_reg(9'h100, 32'h0);
    repeat (3) @(posedge clk);
    chk(pad_oe, 7'h7f);
    chk(pad_o, 7'h00);
    cfg_all(8'h01);
    pad_i <= 7'h55;
    repeat (3) @(posedge clk);
    rd_reg(9'h104);
    chk(rdv, 32'h55);
    chk(sense, 5'h00);
    cfg_all(8'h03);
    rd_reg(9'h104);
    chk(rdv, 32'h2a);
    cfg_all(8'h01);
    pad_i <= 7'h00;
  endtask : t_drive

  task automatic t_alt_out();
    int         pn[12] = '{0, 1, 1, 1, 2, 2, 3, 3, 3, 4, 4, 4};
    logic [7:0] cv[12] = '{8'h04, 8'h0c, 8'h08, 8'h04, 8'h0c, 8'h08,
                           8'h08, 8'h04, 8'h0c, 8'h08, 8'h04, 8'h0c};
    int         sr[12] = '{0, 3, 5, 7, 4, 6, 1, 8, 15, 2, 9, 15};
    for (int i = 0; i < 12; i++) begin
      alt <= (sr[i] == 15) ? 10'h3ff : 10'h001 << sr[i];
      wr_reg(ca(pn[i]), {24'h0, cv[i]});
      repeat (3) @(posedge clk);
      chk(pad_oe[pn[i]], 1'b1);
      chk(pad_o[pn[i]], sr[i] != 15);
      wr_reg(ca(pn[i]), {24'h0, cv[i] | 8'h02});
      repeat (3) @(posedge clk);
      chk(pad_o[pn[i]], sr[i] == 15);
      wr_reg(ca(pn[i]), 32'h01);
    end
    alt <= '0;
  endtask : t_alt_out

  task automatic t_alt_in();
    int pn[5] = '{1, 3, 2, 5, 6};
    for (int i = 0; i < 5; i++) begin
      pad_i <= 7'h01 << pn[i];
      wr_reg(ca(pn[i]), 32'h05);
      repeat (4) @(posedge clk);
      chk(sense, 5'h01 << i);
      wr_reg(ca(pn[i]), 32'h07);
      repeat (4) @(posedge clk);
      chk(sense, 5'h00);
      wr_reg(ca(pn[i]), 32'h01);
    end
    pad_i <= '0;
  endtask : t_alt_in

  task automatic t_main_rst();
    for (int k = 0; k < 2; k++) begin
      wr_reg(ca(4), 32'h85);
      wr_reg(ca(3), 32'h85);
      if (k == 0) mpor <= 1'b1;
      else hrst <= 1'b1;
      @(posedge clk);
      mpor <= 1'b0;
      hrst <= 1'b0;
      rd_reg(ca(4));
      chk(rdv, 32'h00);
      rd_reg(ca(3));
      chk(rdv, 32'h85);
    end
    do_reset();
    rd_reg(ca(4));
    chk(rdv, 32'h01);
  endtask : t_main_rst

  initial begin
    do_reset();
    t_reset_vals();
    t_masks();
    t_bus_err();
    t_drive();
    t_alt_out();
    t_alt_in();
    t_main_rst();
    print_verdict();
  end
endmodule : gpcfg_top_tb

`default_nettype wire
